// ==== logic/saturating_simd_abs_unit.sv ====
// Purpose: Packed saturating absolute value for six fixed-point SIMD forms
// Assumes: Operand read from the register file in the issue cycle
// Notes:   One cycle from issue to writeback; sticky flag set via a set mask
`timescale 1ns/1ps
`include "abs_sat_defines.svh"

// Contract
// - Eight bytes: per-lane absolute value
// - Byte 0x80 becomes 0x7f
// - Any clamp sets sticky bit 20
// - Pair halfwords use low 32 bits only
// - Pair halfwords sign-extend upper result half
// - Halfword 0x8000 becomes 0x7fff
// - Pair words abs, 0x80000000 clamps
// - Four bytes low half, sign-extended
// - Four halfwords, all lanes, no extension
// - Operand values never raise exceptions
// - Only reserved or disabled exceptions
// - Decode 64-bit-lane group, rs zero
// - Decode 32-bit-lane group sub-ops
// - All forms and formats are supported
// - Single word clamps and sign-extends
module saturating_simd_abs_unit
    import abs_sat_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // Issue from decode
    input  wire logic        i_issue_valid,
    input  wire logic [31:0] i_instr,
    input  wire logic [63:0] i_src_data,
    input  wire logic        i_ext_enabled,
    // Writeback and flags
    output wb_t              o_wb,
    output logic [31:0]      o_ctrl_set_mask,
    output exc_t             o_exc
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    // Instruction fields
    wire logic [5:0] major_f = i_instr[`MAJOR_HI:`MAJOR_LO];
    wire logic [4:0] rs_f    = i_instr[`RS_HI:`RS_LO];
    wire logic [4:0] subop_f = i_instr[`SUBOP_HI:`SUBOP_LO];
    wire logic [5:0] func_f  = i_instr[`FUNC_HI:`FUNC_LO];

    // Group and form hits
    wire logic grp64 = (major_f == `EXT_MAJOR) && (func_f == `FUNC_LANE64);
    wire logic grp32 = (major_f == `EXT_MAJOR) && (func_f == `FUNC_LANE32);
    wire logic hit_ob = grp64 && (subop_f == `SUBOP_OB);
    wire logic hit_pw = grp64 && (subop_f == `SUBOP_PW);
    wire logic hit_qh = grp64 && (subop_f == `SUBOP_QH);
    wire logic hit_ph = grp32 && (subop_f == `SUBOP_PH);
    wire logic hit_qb = grp32 && (subop_f == `SUBOP_QB);
    wire logic hit_w  = grp32 && (subop_f == `SUBOP_W);
    wire logic ours   = hit_ob | hit_pw | hit_qh | hit_ph | hit_qb | hit_w;

    // Exception causes come only from encoding and enable
    wire logic take       = i_issue_valid && ours;
    wire logic bad_rs     = take && (rs_f != `RS_ZERO);
    wire logic disabled   = take && !bad_rs && !i_ext_enabled;
    wire logic go         = take && !bad_rs && i_ext_enabled;

    // Form select
    abs_form_t form;
    always_comb begin
        case (1'b1)
            hit_ob:  form = FORM_OB;
            hit_qb:  form = FORM_QB;
            hit_ph:  form = FORM_PH;
            hit_qh:  form = FORM_QH;
            hit_pw:  form = FORM_PW;
            hit_w:   form = FORM_W;
            default: form = FORM_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lanes

    logic [63:0] b_mag;
    logic [7:0]  b_clamp;
    logic [63:0] h_mag;
    logic [3:0]  h_clamp;
    logic [63:0] w_mag;
    logic [1:0]  w_clamp;

    // Byte lanes
    for (genvar i = 0; i < 8; i++) begin : g_byte
        sat_abs_lane #(.W(8)) u_lane (
            .i_operand   (i_src_data[8*i +: 8]),
            .o_magnitude (b_mag[8*i +: 8]),
            .o_clamped   (b_clamp[i])
        );
    end

    // Halfword lanes
    for (genvar i = 0; i < 4; i++) begin : g_half
        sat_abs_lane #(.W(16)) u_lane (
            .i_operand   (i_src_data[16*i +: 16]),
            .o_magnitude (h_mag[16*i +: 16]),
            .o_clamped   (h_clamp[i])
        );
    end

    // Word lanes
    for (genvar i = 0; i < 2; i++) begin : g_word
        sat_abs_lane #(.W(32)) u_lane (
            .i_operand   (i_src_data[32*i +: 32]),
            .o_magnitude (w_mag[32*i +: 32]),
            .o_clamped   (w_clamp[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result assembly

    logic [63:0] res_next;
    logic        clamp_next;
    always_comb begin
        case (form)
            FORM_OB: begin
                res_next   = b_mag;
                clamp_next = |b_clamp;
            end
            FORM_QB: begin
                res_next   = {{32{b_mag[31]}}, b_mag[31:0]};
                clamp_next = |b_clamp[3:0];
            end
            FORM_PH: begin
                res_next   = {{32{h_mag[31]}}, h_mag[31:0]};
                clamp_next = |h_clamp[1:0];
            end
            FORM_QH: begin
                res_next   = h_mag;
                clamp_next = |h_clamp;
            end
            FORM_PW: begin
                res_next   = w_mag;
                clamp_next = |w_clamp;
            end
            FORM_W: begin
                res_next   = {{32{w_mag[31]}}, w_mag[31:0]};
                clamp_next = w_clamp[0];
            end
            default: begin
                res_next   = `RESULT_RST;
                clamp_next = 1'b0;
            end
        endcase
    end

    // Set mask: only the sticky bit, only on a clamp
    wire logic [31:0] set_mask_next =
        (go && clamp_next) ? (32'h0000_0001 << `OUFLAG_BIT) : `CTRL_SET_NONE;

    ////////////////////////////////////////////////////////////////////////////
    // Output registers

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_wb            <= '0;
            o_ctrl_set_mask <= `CTRL_SET_NONE;
            o_exc           <= '0;
        end else begin
            o_wb.valid      <= go;
            o_wb.dest       <= i_instr[`RD_HI:`RD_LO];
            o_wb.result     <= go ? res_next : `RESULT_RST;
            o_ctrl_set_mask <= set_mask_next;
            o_exc.reserved  <= bad_rs;
            o_exc.disabled  <= disabled;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Delayed copies for the checks
    logic [63:0] src_q;
    logic        go_q;
    abs_form_t   form_q;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            src_q  <= '0;
            go_q   <= 1'b0;
            form_q <= FORM_NONE;
        end else begin
            src_q  <= i_src_data;
            go_q   <= go;
            form_q <= form;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // Issue of one form followed by its writeback
    sequence s_issue_ph;
        go && (form == FORM_PH);
    endsequence
    sequence s_wb_ext;
        o_wb.valid && (o_wb.result[63:32] == {32{o_wb.result[31]}});
    endsequence

    eight_byte_top_a: assert property (go_q && form_q == FORM_OB && !src_q[63]
        |-> o_wb.result[63:56] == src_q[63:56])
        else $error("eight-byte lane 7 did not pass through");
    byte_clamp_a: assert property (go && form == FORM_OB && i_src_data[7:0] == 8'h80
        |=> o_wb.result[7:0] == 8'h7f)
        else $error("byte minimum not clamped");
    flag_set_a: assert property (go && clamp_next
        |=> o_ctrl_set_mask[`OUFLAG_BIT] && o_ctrl_set_mask == 32'h0010_0000)
        else $error("clamp did not set sticky flag");
    flag_quiet_a: assert property (!(go && clamp_next)
        |=> o_ctrl_set_mask == 32'h0000_0000)
        else $error("sticky flag set without clamp");
    pair_half_ext_a: assert property (s_issue_ph |=> s_wb_ext)
        else $error("paired halfword upper half not sign fill");
    pair_half_low_a: assert property (go_q && form_q == FORM_PH
        |-> o_wb.result[31:16] == (src_q[31:16] == 16'h8000 ? 16'h7fff :
            src_q[31] ? 16'(-src_q[31:16]) : src_q[31:16]))
        else $error("paired halfword lane 1 wrong");
    half_clamp_a: assert property (go && form == FORM_QH && i_src_data[63:48] == 16'h8000
        |=> o_wb.result[63:48] == 16'h7fff)
        else $error("halfword minimum not clamped");
    pair_word_a: assert property (go_q && form_q == FORM_PW
        |-> o_wb.result[63:32] == (src_q[63:32] == 32'h8000_0000 ? 32'h7fff_ffff :
            src_q[63] ? 32'(-src_q[63:32]) : src_q[63:32]))
        else $error("paired word upper lane wrong");
    four_byte_ext_a: assert property (go && form == FORM_QB
        |=> o_wb.result[63:32] == {32{o_wb.result[31]}})
        else $error("four-byte result not sign filled");
    single_word_a: assert property (go && form == FORM_W && i_src_data[31:0] == 32'h8000_0000
        |=> o_wb.result == 64'h0000_0000_7fff_ffff)
        else $error("single word minimum not clamped");
    no_data_exc_a: assert property (go |=> !o_exc.reserved && !o_exc.disabled)
        else $error("exception raised on valid operands");
    disabled_exc_a: assert property (disabled |=> o_exc.disabled && !o_wb.valid)
        else $error("disabled extension not reported");
    rs_exc_a: assert property (bad_rs |=> o_exc.reserved && !o_wb.valid)
        else $error("nonzero rs not reported");

endmodule : saturating_simd_abs_unit

// ==== logic/abs_sat_defines.svh ====
// Purpose: Encodings, field positions and flag positions for the saturating abs unit
// Assumes: 32-bit instruction word, 64-bit general registers
// Notes:   Definitions only
`ifndef ABS_SAT_DEFINES_SVH
`define ABS_SAT_DEFINES_SVH

// Instruction field positions
`define MAJOR_HI        31
`define MAJOR_LO        26
`define RS_HI           25
`define RS_LO           21
`define RT_HI           20
`define RT_LO           16
`define RD_HI           15
`define RD_LO           11
`define SUBOP_HI        10
`define SUBOP_LO        6
`define FUNC_HI         5
`define FUNC_LO         0

// Field values
`define EXT_MAJOR       6'h1f
`define FUNC_LANE64     6'h16
`define FUNC_LANE32     6'h12
`define RS_ZERO         5'h00
`define SUBOP_OB        5'h01
`define SUBOP_PW        5'h11
`define SUBOP_QH        5'h09
`define SUBOP_PH        5'h09
`define SUBOP_QB        5'h01
`define SUBOP_W         5'h11

// Extension control register: overflow/underflow sticky flag
`define CTRL_W          32
`define OUFLAG_BIT      20
`define CTRL_SET_NONE   32'h0000_0000

// Result reset value
`define RESULT_RST      64'h0000_0000_0000_0000

`endif

// ==== logic/abs_sat_pkg.sv ====
// Purpose: Types shared by the saturating abs unit
// Assumes: Constants come from abs_sat_defines.svh
// Notes:   Form codes written out in binary
package abs_sat_pkg;

    // Selected instruction form
    typedef enum logic [2:0] {
        FORM_NONE = 3'b000,
        FORM_OB   = 3'b001,
        FORM_QB   = 3'b010,
        FORM_PH   = 3'b011,
        FORM_QH   = 3'b100,
        FORM_PW   = 3'b101,
        FORM_W    = 3'b110
    } abs_form_t;

    // Writeback bundle
    typedef struct packed {
        logic        valid;
        logic [4:0]  dest;
        logic [63:0] result;
    } wb_t;

    // Exception bundle
    typedef struct packed {
        logic reserved;
        logic disabled;
    } exc_t;

endpackage : abs_sat_pkg

// ==== logic/sat_abs_lane.sv ====
// Purpose: Saturating absolute value of one signed fixed-point element
// Assumes: Two's complement element of width W
// Notes:   Purely combinational
`timescale 1ns/1ps

module sat_abs_lane #(
    parameter int W = 8
) (
    // Element in
    input  wire logic [W-1:0] i_operand,
    // Element out
    output logic      [W-1:0] o_magnitude,
    output logic              o_clamped
);

    // Most negative and largest positive values
    wire logic [W-1:0] most_neg = {1'b1, {(W-1){1'b0}}};
    wire logic [W-1:0] most_pos = {1'b0, {(W-1){1'b1}}};
    wire logic [W-1:0] negated  = ~i_operand + {{(W-1){1'b0}}, 1'b1};

    // Clamp, negate or pass
    assign o_clamped   = (i_operand == most_neg);
    assign o_magnitude = o_clamped    ? most_pos :
                         i_operand[W-1] ? negated : i_operand;

endmodule : sat_abs_lane

// ==== verif/regfile_model.sv ====
// Purpose: Control register owner beside the abs unit
// Assumes: Set mask arrives one cycle after issue
// Notes:   Sticky bits only ever set, cleared by reset
`timescale 1ns/1ps
module regfile_model
    import abs_sat_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // From the unit
    input  wire logic [31:0] i_ctrl_set_mask,
    // Control register view
    output logic      [31:0] o_ctrl_reg
);
    // Sticky accumulate of set requests
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_ctrl_reg <= 32'h0000_0000;
        end else begin
            o_ctrl_reg <= o_ctrl_reg | i_ctrl_set_mask;
        end
    end
endmodule : regfile_model

// ==== verif/saturating_simd_abs_unit_tb.sv ====
// Purpose: Self-checking bench for the saturating abs unit
// Assumes: Inputs driven at falling edge, results one cycle later
// Notes:   Expected values come from a bench-side lane model
`timescale 1ns/1ps
module saturating_simd_abs_unit_tb;
    import abs_sat_pkg::*;
    logic        i_clk = 0, i_sys_rst = 1, i_issue_valid = 0, i_ext_enabled = 1;
    logic [31:0] i_instr = 32'h0, o_ctrl_set_mask, ctrl_reg;
    logic [63:0] i_src_data = 64'h0;
    wb_t         o_wb;
    exc_t        o_exc;
    int          fails = 0, num_checks = 0;

    always #20 i_clk = ~i_clk;

    saturating_simd_abs_unit saturating_simd_abs_unit_inst (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .i_issue_valid(i_issue_valid), .i_instr(i_instr),
        .i_src_data(i_src_data), .i_ext_enabled(i_ext_enabled), .o_wb(o_wb),
        .o_ctrl_set_mask(o_ctrl_set_mask), .o_exc(o_exc));
    regfile_model regfile_model_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_ctrl_set_mask(o_ctrl_set_mask), .o_ctrl_reg(ctrl_reg));

    ////////////////////////////////////////////////////////////////////////////
    task end_sim;
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // Flag in bit 64, result below
    function automatic logic [64:0] exp_abs(abs_form_t f, logic [63:0] s);
        int w, n;
        logic [63:0] r, mk;
        logic [31:0] e, m;
        logic c;
        w = (f == FORM_OB || f == FORM_QB) ? 8 : (f == FORM_PH || f == FORM_QH) ? 16 : 32;
        n = (f == FORM_QB || f == FORM_PH || f == FORM_W) ? 32 / w : 64 / w;
        mk = (64'h1 << w) - 64'h1;
        r = 64'h0;
        c = 1'b0;
        for (int i = 0; i < n; i++) begin
            e = 32'(s >> (i * w)) & 32'(mk);
            if (e == (32'h1 << (w - 1))) begin
                m = 32'(mk) >> 1;
                c = 1'b1;
            end else if (e[w-1]) m = (~e + 32'h1) & 32'(mk);
            else m = e;
            r = r | (64'(m) << (i * w));
        end
        if (n * w == 32) r[63:32] = {32{r[31]}};
        return {c, r};
    endfunction : exp_abs

    function automatic logic [31:0] enc(abs_form_t f, logic [4:0] rs, logic [4:0] rd);
        logic [10:0] sf;
        case (f)
            FORM_OB: sf = {5'h01, 6'h16};
            FORM_PW: sf = {5'h11, 6'h16};
            FORM_QH: sf = {5'h09, 6'h16};
            FORM_PH: sf = {5'h09, 6'h12};
            FORM_QB: sf = {5'h01, 6'h12};
            default: sf = {5'h11, 6'h12};
        endcase
        return {6'h1f, rs, 5'h02, rd, sf};
    endfunction : enc

    // Kind: 0 normal, 1 reserved, 2 disabled, 3 ignored
    task op(input logic [31:0] ins, input logic en, input logic [63:0] s, input abs_form_t f,
            input int kind);
        logic [64:0] e;
        e = (kind == 0) ? exp_abs(f, s) : 65'h0;
        i_instr = ins;
        i_src_data = s;
        i_ext_enabled = en;
        i_issue_valid = 1'b1;
        @(negedge i_clk);
        chk("wb_valid", 64'(o_wb.valid), 64'(kind == 0));
        chk("wb_dest", 64'(o_wb.dest), 64'(ins[15:11]));
        chk("result", o_wb.result, e[63:0]);
        chk("set_mask", 64'(o_ctrl_set_mask), 64'(e[64]) << 20);
        chk("exc", 64'(o_exc), {62'h0, kind == 1, kind == 2});
    endtask : op

    task idle;
        i_issue_valid = 1'b0;
        @(negedge i_clk);
    endtask : idle

    ////////////////////////////////////////////////////////////////////////////
    task t_bytes;
        op(enc(FORM_OB, 0, 5), 1, 64'h807f_8101_00ff_c380, FORM_OB, 0);
        op(enc(FORM_OB, 0, 12), 1, 64'h3a01_fe7f_8081_00c0, FORM_OB, 0);
        op(enc(FORM_QB, 0, 6), 1, 64'hdead_beef_8005_fb7f, FORM_QB, 0);
        op(enc(FORM_QB, 0, 7), 1, 64'h8000_0000_ff01_7e02, FORM_QB, 0);
        idle;
    endtask : t_bytes

    task t_halves;
        op(enc(FORM_PH, 0, 3), 1, 64'h8000_1234_8000_0005, FORM_PH, 0);
        op(enc(FORM_PH, 0, 4), 1, 64'hffff_ffff_fffe_7fff, FORM_PH, 0);
        op(enc(FORM_QH, 0, 8), 1, 64'h8000_ffff_7fff_8001, FORM_QH, 0);
        idle;
    endtask : t_halves

    task t_words;
        op(enc(FORM_PW, 0, 9), 1, 64'h8000_0000_ffff_fffe, FORM_PW, 0);
        op(enc(FORM_W, 0, 10), 1, 64'h1234_5678_8000_0000, FORM_W, 0);
        op(enc(FORM_W, 0, 11), 1, 64'hffff_ffff_c000_0000, FORM_W, 0);
        idle;
    endtask : t_words

    task t_refused;
        op(enc(FORM_OB, 1, 5), 1, 64'h8080_8080_8080_8080, FORM_OB, 1);
        op(enc(FORM_PH, 3, 5), 0, 64'h8000_8000_8000_8000, FORM_PH, 1);
        op(enc(FORM_QH, 0, 5), 0, 64'h8000_8000_8000_8000, FORM_QH, 2);
        op({enc(FORM_OB, 0, 5)} ^ 32'h0000_0005, 1, 64'h80, FORM_OB, 3);
        idle;
    endtask : t_refused

    task t_sticky;
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_sys_rst = 1'b0;
        idle;
        chk("ctrl_after_rst", 64'(ctrl_reg), 64'h0);
        op(enc(FORM_W, 0, 2), 1, 64'h0000_0000_0000_0005, FORM_W, 0);
        idle;
        chk("ctrl_no_clamp", 64'(ctrl_reg), 64'h0);
        op(enc(FORM_QB, 0, 2), 1, 64'h0000_0000_0000_0080, FORM_QB, 0);
        op(enc(FORM_QH, 0, 2), 1, 64'h0000_0000_0000_0001, FORM_QH, 0);
        idle;
        chk("ctrl_sticky", 64'(ctrl_reg), 64'h0010_0000);
    endtask : t_sticky

    // Main sequence
    initial begin
        repeat (20) @(negedge i_clk);
        i_sys_rst = 1'b0;
        idle;
        t_bytes;
        t_halves;
        t_words;
        t_refused;
        t_sticky;
        end_sim;
    end

    // Watchdog
    initial begin
        repeat (2000) @(posedge i_clk);
        fails++;
        end_sim;
    end
endmodule : saturating_simd_abs_unit_tb
